// ---- inc/twi_pkg.sv ----
// Shared constants, register map and carrier types for the two-wire status block
package twi_pkg;

  // Clock of the register side, in ns
  localparam int unsigned CLK_PERIOD_NS = 20;

  // Least time in ns to whole clock cycles, never below one
  function automatic int unsigned ns_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Condition timing, ns as given
  localparam int unsigned SETUP_STD_NS    = 5600;
  localparam int unsigned SETUP_FAST_NS   = 2100;
  localparam int unsigned HOLD_STD_NS     = 4800;
  localparam int unsigned HOLD_FAST_NS    = 2300;
  localparam int unsigned BUSY_STD_NS     = 3500;
  localparam int unsigned BUSY_FAST_NS    = 750;
  localparam int unsigned SCL_HALF_STD_NS  = 5000;
  localparam int unsigned SCL_HALF_FAST_NS = 1250;

  localparam logic [9:0] SETUP_STD_CYC    = 10'(ns_up(SETUP_STD_NS));
  localparam logic [9:0] SETUP_FAST_CYC   = 10'(ns_up(SETUP_FAST_NS));
  localparam logic [9:0] HOLD_STD_CYC     = 10'(ns_up(HOLD_STD_NS));
  localparam logic [9:0] HOLD_FAST_CYC    = 10'(ns_up(HOLD_FAST_NS));
  localparam logic [9:0] BUSY_STD_CYC     = 10'(ns_up(BUSY_STD_NS));
  localparam logic [9:0] BUSY_FAST_CYC    = 10'(ns_up(BUSY_FAST_NS));
  localparam logic [9:0] SCL_HALF_STD_CYC  = 10'(ns_up(SCL_HALF_STD_NS));
  localparam logic [9:0] SCL_HALF_FAST_CYC = 10'(ns_up(SCL_HALF_FAST_NS));

  // Delay from a data load to byte-done pending rising again
  localparam logic [3:0] PIN_SET_DELAY_CYC = 4'hC;

  // Bit counter values: eight data bits then the acknowledge clock
  localparam logic [3:0] BITS_DATA = 4'h8;
  localparam logic [3:0] BITS_ACK  = 4'h9;

  // Register byte offsets
  localparam logic [7:0] STATUS_OFS  = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] OWN_ADR_OFS = 8'h08;
  localparam logic [7:0] SHIFT_OFS   = 8'h0C;
  localparam logic [7:0] TXBUF_OFS   = 8'h10;

  // Values after reset
  localparam logic [7:0] STATUS_RST  = 8'h10;
  localparam logic [3:0] CONTROL_RST = 4'h0;
  localparam logic [7:0] OWN_ADR_RST = 8'h00;

  // Status register layout, bit 7 first
  typedef struct packed {
    logic master_select;
    logic transmit_direction;
    logic bus_busy_flag;
    logic byte_done_pending_n;
    logic arbitration_lost_flag;
    logic address_match_flag;
    logic general_call_flag;
    logic last_rx_bit;
  } status_t;

  // Control register writable bits 6..3
  typedef struct packed {
    logic fast_mode;
    logic ten_bit_addr;
    logic free_format_select;
    logic interface_enable;
  } control_t;

  // Master condition and clock generator, one-hot
  typedef enum logic [7:0] {
    M_IDLE     = 8'h01,
    M_START_SU = 8'h02,
    M_START_HD = 8'h04,
    M_LOW      = 8'h08,
    M_HIGH     = 8'h10,
    M_HOLD     = 8'h20,
    M_STOP_SU  = 8'h40,
    M_STOP_HD  = 8'h80
  } mstate_t;

endpackage

// ---- rtl/twi_status_cond.sv ----
// Two-wire bus status flags, byte engine and START/STOP generator behind Wishbone
`timescale 1ns/1ps

// How it works
// R1 - General call sets flag; START/STOP clear it
// R2 - 7-bit: upper seven bits or general call match
// R3 - 10-bit: all eight own-address bits match
// R4 - Shift or buffer write clears address match
// R5 - Arbitration loss: flag, receive, master drops later
// R6 - Loser in address byte keeps recognising address
// R7 - Last SCL fall clears pending, raises request
// R8 - Pending low holds SCL low
// R9 - Pending set by write, load, disable, reset
// R10 - Pending rises twelve cycles after load
// R11 - Pending cleared after each relevant byte
// R12 - Busy follows START/STOP; zero when disabled
// R13 - Busy bus refuses START, counter, SCL
// R14 - Slave address R/W bit sets direction
// R15 - Direction cleared on listed events
// R16 - Master select cleared on listed events
// R17 - Master drives SCL/conditions; transmitter drives SDA
// R18 - Status write 111 generates START and byte
// R19 - Status write 110 generates STOP
// R20 - Condition setup and hold least times
// R21 - Busy changes 3.5 or 0.75 us after
module twi_status_cond (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Two-wire link, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Request to the CPU
  output logic             serial_bus_irq
);

  // Line sampling
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Register state
  twi_pkg::control_t ctrl_r;
  logic [7:0]        own_adr_r;
  logic [7:0]        shift_r;
  logic [3:0]        bitc_r;
  logic              gc_r;
  logic              aas_r;
  logic              al_r;
  logic              pin_r;
  logic              bb_r;
  logic              trx_r;
  logic              mst_r;
  logic              lrb_r;
  twi_pkg::status_t  status_view;

  assign status_view = '{master_select:         mst_r,
                         transmit_direction:    trx_r,
                         bus_busy_flag:         bb_r,
                         byte_done_pending_n:   pin_r,
                         arbitration_lost_flag: al_r,
                         address_match_flag:    aas_r,
                         general_call_flag:     gc_r,
                         last_rx_bit:           lrb_r};

  // Bus decode: one wait state, every access answered
  logic wb_hit;
  logic wr;
  logic wr_status;
  logic wr_ctrl;
  logic wr_own;
  logic en;
  logic load_wr;

  assign wb_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = wb_hit & wb_we_i & wb_sel_i[0];
  assign wr_status = wr && (wb_adr_i == twi_pkg::STATUS_OFS);
  assign wr_ctrl   = wr && (wb_adr_i == twi_pkg::CONTROL_OFS);
  assign wr_own    = wr && (wb_adr_i == twi_pkg::OWN_ADR_OFS);
  assign en        = ctrl_r.interface_enable;
  // Data loads are ignored while the interface is disabled
  assign load_wr   = wr & en & ((wb_adr_i == twi_pkg::SHIFT_OFS) |
                                (wb_adr_i == twi_pkg::TXBUF_OFS));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          twi_pkg::STATUS_OFS:  wb_dat_o[7:0] <= status_view;
          twi_pkg::CONTROL_OFS: wb_dat_o[7:0] <= {1'b0, ctrl_r, bitc_r[2:0]};
          twi_pkg::OWN_ADR_OFS: wb_dat_o[7:0] <= own_adr_r;
          twi_pkg::SHIFT_OFS:   wb_dat_o[7:0] <= shift_r;
          default:              wb_dat_o      <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= twi_pkg::CONTROL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= wb_dat_i[6:3];
    end
  end

  // The match bit of the own address drops at a STOP; a write in the same cycle wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      own_adr_r <= twi_pkg::OWN_ADR_RST;
    end else if (wr_own) begin
      own_adr_r <= wb_dat_i[7:0];
    end else if (stop_det) begin
      own_adr_r[0] <= 1'b0;
    end
  end

  // Commands carried by status writes
  logic start_cmd;
  logic stop_cmd;
  logic start_ok;
  logic start_dup;

  // R18 START command
  assign start_cmd = wr_status & en & wb_dat_i[7] & wb_dat_i[6] & wb_dat_i[5];
  // R19 STOP command
  assign stop_cmd  = wr_status & en & wb_dat_i[7] & wb_dat_i[6] & ~wb_dat_i[5];
  // R13 duplicate START refused
  assign start_ok  = start_cmd & (~bb_r | mst_r);
  assign start_dup = start_cmd & bb_r & ~mst_r;

  // Byte engine events
  logic slave_ctx;
  logic addr_phase_r;
  logic addr_eval;
  logic byte_end;
  logic gcall;
  logic addr_hit;
  logic pin_clear;
  logic arb_lost;
  logic tx_bit_r;
  logic ack_low_r;
  logic go_r;

  // R6 address still compared after a lost arbitration
  assign slave_ctx = ~mst_r | al_r;
  assign addr_eval = scl_fall && (bitc_r == twi_pkg::BITS_DATA) && addr_phase_r && slave_ctx;
  assign byte_end  = scl_fall && (bitc_r == twi_pkg::BITS_ACK);
  assign gcall     = (shift_r == 8'h00);
  // R2 seven-bit compare
  // R3 ten-bit compare
  assign addr_hit  = ctrl_r.ten_bit_addr ? ((shift_r == own_adr_r) | gcall)
                                         : ((shift_r[7:1] == own_adr_r[7:1]) | gcall);
  // R11 which bytes raise byte-done
  assign pin_clear = byte_end &
                     (mst_r | trx_r | aas_r | gc_r | ctrl_r.free_format_select);
  // R5 own high bit overridden
  assign arb_lost  = scl_rise && mst_r && trx_r && (bitc_r < twi_pkg::BITS_DATA) &&
                     tx_bit_r && !sda_s;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_r      <= 8'h00;
      bitc_r       <= 4'h0;
      addr_phase_r <= 1'b0;
      tx_bit_r     <= 1'b1;
      ack_low_r    <= 1'b0;
    end else if (!en) begin
      bitc_r       <= 4'h0;
      addr_phase_r <= 1'b0;
      tx_bit_r     <= 1'b1;
      ack_low_r    <= 1'b0;
    end else if (load_wr) begin
      shift_r  <= wb_dat_i[7:0];
      tx_bit_r <= wb_dat_i[7];
      bitc_r   <= 4'h0;
    end else if (start_det) begin
      bitc_r       <= 4'h0;
      addr_phase_r <= 1'b1;
      ack_low_r    <= 1'b0;
    end else if (stop_det) begin
      bitc_r       <= 4'h0;
      addr_phase_r <= 1'b0;
      ack_low_r    <= 1'b0;
    end else if (scl_rise) begin
      if (bitc_r < twi_pkg::BITS_DATA) begin
        shift_r <= {shift_r[6:0], sda_s};
      end
      bitc_r <= bitc_r + 4'h1;
    end else if (scl_fall) begin
      if (bitc_r == twi_pkg::BITS_DATA) begin
        tx_bit_r <= 1'b1;
        if (addr_phase_r) begin
          ack_low_r <= slave_ctx & ~ctrl_r.free_format_select & addr_hit;
        end else begin
          ack_low_r <= ~trx_r & (mst_r | aas_r | gc_r | ctrl_r.free_format_select);
        end
      end else if (bitc_r == twi_pkg::BITS_ACK) begin
        bitc_r       <= 4'h0;
        addr_phase_r <= 1'b0;
        ack_low_r    <= 1'b0;
        tx_bit_r     <= shift_r[7];
      end else begin
        // Next bit is put out while SCL is low only
        tx_bit_r <= shift_r[7];
      end
    end
  end

  // R1 general call
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gc_r <= 1'b0;
    end else if (addr_eval && !ctrl_r.free_format_select && gcall) begin
      gc_r <= 1'b1;
    end else if (start_det || stop_det) begin
      gc_r <= 1'b0;
    end
  end

  // R4 load clears match; a match in the same cycle wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aas_r <= 1'b0;
    end else if (addr_eval && !ctrl_r.free_format_select && addr_hit) begin
      aas_r <= 1'b1;
    end else if (load_wr) begin
      aas_r <= 1'b0;
    end
  end

  // R5 arbitration flag, cleared only by disabling
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      al_r <= 1'b0;
    end else if (!en) begin
      al_r <= 1'b0;
    end else if (arb_lost) begin
      al_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lrb_r <= 1'b0;
    end else if (scl_rise && bitc_r == twi_pkg::BITS_DATA) begin
      lrb_r <= sda_s;
    end else if (load_wr) begin
      lrb_r <= 1'b0;
    end
  end

  // R10 delayed set after a load
  logic [3:0] pin_cnt_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_cnt_r <= 4'h0;
    end else if (load_wr) begin
      pin_cnt_r <= twi_pkg::PIN_SET_DELAY_CYC;
    end else if (pin_cnt_r != 4'h0) begin
      pin_cnt_r <= pin_cnt_r - 4'h1;
    end
  end

  // R9 set sources; byte completion wins so no byte is lost
  // R7 cleared at the last SCL fall
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_r <= 1'b1;
    end else if (!en) begin
      pin_r <= 1'b1;
    end else if (pin_clear) begin
      pin_r <= 1'b0;
    end else if ((wr_status && wb_dat_i[4]) || pin_cnt_r == 4'h1) begin
      pin_r <= 1'b1;
    end
  end

  // R7 request on byte done; slave STOP too
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      serial_bus_irq <= 1'b0;
    end else begin
      serial_bus_irq <= (pin_clear & pin_r) | (en & stop_det & ~mst_r);
    end
  end

  // Master clock and condition generator
  twi_pkg::mstate_t mstate_r;
  logic [9:0]       tmr_r;
  logic             stop_pend_r;
  logic [9:0]       setup_cyc;
  logic [9:0]       hold_cyc;
  logic [9:0]       half_cyc;
  logic [9:0]       busy_cyc;

  // R20 least setup and hold per speed
  assign setup_cyc = ctrl_r.fast_mode ? twi_pkg::SETUP_FAST_CYC : twi_pkg::SETUP_STD_CYC;
  assign hold_cyc  = ctrl_r.fast_mode ? twi_pkg::HOLD_FAST_CYC : twi_pkg::HOLD_STD_CYC;
  assign half_cyc  = ctrl_r.fast_mode ? twi_pkg::SCL_HALF_FAST_CYC : twi_pkg::SCL_HALF_STD_CYC;
  assign busy_cyc  = ctrl_r.fast_mode ? twi_pkg::BUSY_FAST_CYC : twi_pkg::BUSY_STD_CYC;

  // Only a shift-register write releases the next byte; a buffer write keeps SCL held
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      go_r <= 1'b0;
    end else if (load_wr && wb_adr_i == twi_pkg::SHIFT_OFS && mst_r) begin
      go_r <= 1'b1;
    end else if (mstate_r != twi_pkg::M_HOLD) begin
      go_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mstate_r    <= twi_pkg::M_IDLE;
      tmr_r       <= 10'h000;
      stop_pend_r <= 1'b0;
    end else if (!en) begin
      mstate_r    <= twi_pkg::M_IDLE;
      tmr_r       <= 10'h000;
      stop_pend_r <= 1'b0;
    end else begin
      if (tmr_r != 10'h000) begin
        tmr_r <= tmr_r - 10'h001;
      end
      if (stop_cmd && mst_r) begin
        stop_pend_r <= 1'b1;
      end
      unique case (mstate_r)
        twi_pkg::M_IDLE: begin
          // R18 begin START
          if (start_ok) begin
            mstate_r <= twi_pkg::M_START_SU;
            tmr_r    <= setup_cyc;
          end
        end
        twi_pkg::M_START_SU: begin
          if (tmr_r == 10'h000 && scl_s) begin
            mstate_r <= twi_pkg::M_START_HD;
            tmr_r    <= hold_cyc;
          end
        end
        twi_pkg::M_START_HD: begin
          if (tmr_r == 10'h000) begin
            mstate_r <= twi_pkg::M_LOW;
            tmr_r    <= half_cyc;
          end
        end
        twi_pkg::M_LOW: begin
          if (tmr_r == 10'h000) begin
            mstate_r <= twi_pkg::M_HIGH;
            tmr_r    <= half_cyc;
          end
        end
        twi_pkg::M_HIGH: begin
          // High time counts only once the line is really high
          if (!scl_s) begin
            tmr_r <= half_cyc;
          end else if (tmr_r == 10'h000) begin
            mstate_r <= (bitc_r == twi_pkg::BITS_ACK) ? twi_pkg::M_HOLD : twi_pkg::M_LOW;
            tmr_r    <= half_cyc;
          end
        end
        twi_pkg::M_HOLD: begin
          // R8 held until pending rises
          if (tmr_r != 10'h000) begin
            mstate_r <= twi_pkg::M_HOLD;
          end else if (!mst_r) begin
            mstate_r <= twi_pkg::M_IDLE;
          end else if (stop_pend_r && pin_r) begin
            mstate_r    <= twi_pkg::M_STOP_SU;
            stop_pend_r <= 1'b0;
            tmr_r       <= setup_cyc;
          end else if (start_ok) begin
            mstate_r <= twi_pkg::M_START_SU;
            tmr_r    <= setup_cyc;
          end else if (go_r && pin_r) begin
            mstate_r <= twi_pkg::M_LOW;
            tmr_r    <= half_cyc;
          end
        end
        twi_pkg::M_STOP_SU: begin
          if (tmr_r == 10'h000 && scl_s) begin
            mstate_r <= twi_pkg::M_STOP_HD;
            tmr_r    <= hold_cyc;
          end
        end
        twi_pkg::M_STOP_HD: begin
          if (tmr_r == 10'h000) begin
            mstate_r <= twi_pkg::M_IDLE;
          end
        end
        default: begin
          mstate_r <= twi_pkg::M_IDLE;
        end
      endcase
    end
  end

  // R21 busy timer from the START command or the STOP setup
  logic [9:0] bbt_r;
  logic       bb_tgt_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bbt_r    <= 10'h000;
      bb_tgt_r <= 1'b0;
    end else if (!en) begin
      bbt_r    <= 10'h000;
      bb_tgt_r <= 1'b0;
    end else if (start_ok) begin
      bbt_r    <= busy_cyc;
      bb_tgt_r <= 1'b1;
    end else if (mstate_r == twi_pkg::M_HOLD && tmr_r == 10'h000 && mst_r &&
                 stop_pend_r && pin_r) begin
      bbt_r    <= busy_cyc;
      bb_tgt_r <= 1'b0;
    end else if (bbt_r != 10'h000) begin
      bbt_r <= bbt_r - 10'h001;
    end
  end

  // R12 busy flag sources
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bb_r <= 1'b0;
    end else if (!en) begin
      bb_r <= 1'b0;
    end else if (start_det) begin
      bb_r <= 1'b1;
    end else if (stop_det) begin
      bb_r <= 1'b0;
    end else if (bbt_r == 10'h001) begin
      bb_r <= bb_tgt_r;
    end
  end

  // R15 direction clears; R14 set from R/W bit; software write last
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trx_r <= 1'b0;
    end else if (arb_lost || stop_det || start_dup || (start_det && !mst_r) ||
                 (scl_rise && bitc_r == twi_pkg::BITS_DATA && sda_s && !mst_r)) begin
      trx_r <= 1'b0;
    end else if (addr_eval && !ctrl_r.free_format_select && addr_hit) begin
      trx_r <= shift_r[0];
    end else if (wr_status) begin
      trx_r <= wb_dat_i[6];
    end
  end

  // R16 master select clears
  // R5 dropped once the lost byte completes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mst_r <= 1'b0;
    end else if (stop_det || start_dup || (byte_end && al_r)) begin
      mst_r <= 1'b0;
    end else if (wr_status) begin
      mst_r <= wb_dat_i[7];
    end
  end

  // R17 line drive, open drain
  logic scl_low;
  logic sda_low;

  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    unique case (mstate_r)
      twi_pkg::M_START_HD: begin
        sda_low = 1'b1;
        scl_low = (tmr_r == 10'h000);
      end
      twi_pkg::M_STOP_SU: begin
        // SCL rises a cycle after SDA falls, so nobody sees a false START
        sda_low = 1'b1;
        scl_low = (tmr_r == setup_cyc);
      end
      twi_pkg::M_LOW,
      twi_pkg::M_HOLD:     scl_low = 1'b1;
      default:             scl_low = 1'b0;
    endcase
    if (mstate_r != twi_pkg::M_START_HD && mstate_r != twi_pkg::M_STOP_SU &&
        mstate_r != twi_pkg::M_START_SU && mstate_r != twi_pkg::M_STOP_HD) begin
      sda_low = (trx_r & ~al_r & (bitc_r < twi_pkg::BITS_DATA) & ~tx_bit_r) | ack_low_r;
    end
    // R8 slave stretches while pending is low
    if (!mst_r && !pin_r) begin
      scl_low = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= en & scl_low;
      sda_oe <= en & sda_low;
    end
  end

endmodule

// ---- bench/twi_status_cond_assertions.sv ----
// Port-level checker for the two-wire status block
`timescale 1ns/1ps
module twi_status_cond_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Link
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        serial_bus_irq
);
  logic [9:0] hi_cnt;

  // Raw line is seen before the design's synchroniser, so this never undercounts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) hi_cnt <= 10'h000;
    else if (!scl_i) hi_cnt <= 10'h000;
    else if (hi_cnt != 10'h3FF) hi_cnt <= hi_cnt + 10'h001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_held; scl_oe [*8]; endsequence

  property p_ack_resp; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
  property p_irq_pulse; serial_bus_irq |=> !serial_bus_irq; endproperty
  property p_stretch; serial_bus_irq && scl_oe |-> !scl_i ##1 s_held; endproperty
  property p_open_drain; !scl_o && !sda_o; endproperty
  property p_cond_setup;
    scl_i && $past(scl_i) && $changed(sda_oe) |-> hi_cnt >= twi_pkg::SETUP_FAST_CYC;
  endproperty

  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  a_dat_upper: assert property (p_dat_upper) else $error("upper read data not zero");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  a_stretch: assert property (p_stretch) else $error("clock not held after byte");
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  a_cond_setup: assert property (p_cond_setup) else $error("condition setup short");
endmodule

bind twi_status_cond twi_status_cond_chk chk_u (.clock(clock), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .serial_bus_irq(serial_bus_irq));

// ---- bench/twi_partner.sv ----
// Slave on the far side of the link: acks bytes, can fight for SDA
`timescale 1ns/1ps
module twi_partner (
  // Clock, reset, lines
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        scl,
  input wire logic        sda,
  // Control and observation
  input wire logic        steal,
  output logic            sda_pull,
  output logic [7:0]      rx_byte,
  output logic [7:0]      starts,
  output logic [7:0]      stops
);
  logic [3:0] bits;
  logic       ps;
  logic       pd;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {bits, ps, pd, sda_pull, rx_byte, starts, stops} <= '0;
    end else begin
      ps <= scl;
      pd <= sda;
      if (scl && ps && pd && !sda) begin
        starts <= starts + 8'h01;
        bits <= 4'h0;
      end else if (scl && ps && !pd && sda) stops <= stops + 8'h01;
      if (scl && !ps) begin
        bits <= bits + 4'h1;
        if (bits < 4'h8) rx_byte <= {rx_byte[6:0], sda};
      end
      // pull second bit low when stealing; ack the ninth clock
      if (!scl && ps) begin
        sda_pull <= (bits == 4'h8) || (bits == 4'h1 && steal);
        if (bits == 4'h9) bits <= 4'h0;
      end
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the two-wire status block
`timescale 1ns/1ps
module tb_top;
  logic        clock, arst_n, cyc, stb, we, ack, steal, irq, scl_oe, sda_oe, pull;
  logic [7:0]  adr, a, rxb, starts, stops;
  logic [31:0] dat, q, dq;
  int          errors, n_checks, cycles;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || pull);

  twi_status_cond dut_u (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dq),
    .wb_ack_o(ack), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .serial_bus_irq(irq));
  twi_partner peer_u (.clock(clock), .arst_n(arst_n), .scl(scl), .sda(sda), .steal(steal),
    .sda_pull(pull), .rx_byte(rxb), .starts(starts), .stops(stops));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles > 60000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude;
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= {24'h00_0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = dq;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 100) errors++;
    @(posedge clock);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20000) errors++;
  endtask

  function automatic logic [31:0] st(input logic m, t, b, p, al);
    return {24'h00_0000, m, t, b, p, al, 3'h0};
  endfunction

  initial begin
    {arst_n, cyc, stb, we, adr, dat, steal, errors, n_checks, cycles} = '0;
    void'($urandom(11916));
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(0, twi_pkg::STATUS_OFS, 8'h00);
    chk(q, {24'h00_0000, twi_pkg::STATUS_RST});
    bus(0, 8'h14, 8'h00);
    chk(q, 32'h0000_0000);
    bus(0, twi_pkg::TXBUF_OFS, 8'h00);
    chk(q, 32'h0000_0000);
    bus(1, twi_pkg::CONTROL_OFS, 8'h48);
    a = 8'($urandom) & 8'h7F;
    bus(1, twi_pkg::OWN_ADR_OFS, a);
    bus(0, twi_pkg::OWN_ADR_OFS, 8'h00);
    chk(q, 32'(a));
    for (int i = 0; i < 2; i++) begin
      a = 8'($urandom);
      bus(1, twi_pkg::SHIFT_OFS, a);
      repeat (4) @(posedge clock);
      bus(i == 0, twi_pkg::STATUS_OFS, 8'hF0);
      if (i == 1) chk(q & 32'h10, 32'h0);
      wait_irq();
      bus(0, twi_pkg::STATUS_OFS, 8'h00);
      chk(q & 32'hF9, st(1, 1, 1, 0, 0));
      chk(32'(rxb), 32'(a));
      chk(32'(scl_oe), 32'h1);
    end
    bus(1, twi_pkg::STATUS_OFS, 8'hD0);
    repeat (2000) @(posedge clock);
    chk(32'(stops), 32'h1);
    bus(0, twi_pkg::STATUS_OFS, 8'h00);
    chk(q & 32'hF8, st(0, 0, 0, 1, 0));
    bus(1, twi_pkg::CONTROL_OFS, 8'h08);
    steal <= 1'b1;
    a = 8'($urandom) | 8'hC0;
    bus(1, twi_pkg::SHIFT_OFS, a);
    repeat (4) @(posedge clock);
    bus(1, twi_pkg::STATUS_OFS, 8'hF0);
    wait_irq();
    steal <= 1'b0;
    bus(0, twi_pkg::STATUS_OFS, 8'h00);
    chk(q & 32'hF8, st(0, 0, 1, 0, 1));
    bus(1, twi_pkg::STATUS_OFS, 8'hE0);
    repeat (600) @(posedge clock);
    chk(32'(starts), 32'h2);
    bus(0, twi_pkg::STATUS_OFS, 8'h00);
    chk(q & 32'hF8, st(0, 0, 1, 0, 1));
    bus(1, twi_pkg::CONTROL_OFS, 8'h40);
    bus(0, twi_pkg::STATUS_OFS, 8'h00);
    chk(q & 32'hF8, st(0, 0, 0, 1, 0));
    conclude();
  end
endmodule
